// file: src/usb_cfg_pkg.sv
// Purpose: shared constants and carriers for the usb endpoint configuration registers
// Assumes: byte-addressed register port of aligned words, 32-bit data, one clock
// Notes: register offsets are byte addresses of aligned words
package usb_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_BDT_PAGE1 = 8'h00;
  localparam logic [7:0] ADDR_BDT_PAGE2 = 8'h04;
  localparam logic [7:0] ADDR_BDT_PAGE3 = 8'h08;
  localparam logic [7:0] ADDR_CONFIG1 = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_HW_EVENT = 8'h18;
  localparam logic [7:0] ADDR_EP_BASE = 8'h40;
  // configuration bit positions
  localparam int CFG_EYE_BIT = 7;
  localparam int CFG_MON_BIT = 6;
  localparam int CFG_IDLE_BIT = 4;
  localparam int CFG_ASUSP_BIT = 0;
  localparam logic [7:0] CFG_WMASK = 8'hd1;
  // endpoint bit positions
  localparam int EP_LOW_SPEED_DIRECT_BIT = 7;
  localparam int EP_RETRY_BIT = 6;
  localparam int EP_CONDIS_BIT = 4;
  localparam int EP_RX_BIT = 3;
  localparam int EP_TX_BIT = 2;
  localparam int EP_STALL_BIT = 1;
  localparam int EP_HSHK_BIT = 0;
  localparam logic [7:0] EP0_WMASK = 8'hdf;
  localparam logic [7:0] EPN_WMASK = 8'h1f;
  // page 1 keeps bits 7..1 only
  localparam logic [7:0] PAGE1_WMASK = 8'hfe;
  // interrupt status bits
  localparam int IRQ_STALL_BIT = 0;
  localparam int IRQ_SUSPEND_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // reset value of every implemented byte
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] BUS_ZERO = 32'h00000000;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // decoded per-endpoint controls
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic setup_ok;
    logic handshake_en;
    logic stalled;
  } ep_ctrl_t;
endpackage : usb_cfg_pkg

// file: src/usb_endpoint_config_regs.sv
// Purpose: software-visible configuration of a full-speed usb controller
// Assumes: synchronous active-low reset, inputs synchronous to i_clk
// Notes: packet engine, transceiver and power control live outside
`timescale 1ns/1ps
module usb_endpoint_config_regs
  import usb_cfg_pkg::*;
#(
  parameter int NUM_EP = 16
)(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire usb_cfg_pkg::reg_req_t i_req,
  input wire logic [NUM_EP-1:0] i_stall_event,
  input wire logic i_idle_mode,
  input wire logic i_sleep_entry,
  output logic [31:0] o_rdata,
  output logic [31:0] o_bdt_base,
  output logic o_eye_pattern_test_en,
  output logic o_drive_monitor_en,
  output logic o_module_halted,
  output logic o_auto_suspend_req,
  output logic o_low_speed_direct,
  output logic o_nak_retry_en,
  output usb_cfg_pkg::ep_ctrl_t [NUM_EP-1:0] o_ep_ctrl,
  output logic o_irq
);
  import usb_cfg_pkg::*;

  // whole module state in one packed struct
  typedef struct packed {
    logic [7:0] page1;
    logic [7:0] page2;
    logic [7:0] page3;
    logic [7:0] config1;
    logic [NUM_EP-1:0][7:0] ep;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [31:0] rdata;
    logic [31:0] bdt_base;
    logic eye;
    logic mon;
    logic halted;
    logic asusp;
    logic low_speed_direct;
    logic retry_en;
    ep_ctrl_t [NUM_EP-1:0] ep_ctrl;
    logic irq;
  } state_t;

  state_t st; // registered state
  state_t next_st; // next state

  // endpoint index from a byte address, or -1 when outside the table
  function automatic int ep_index(input logic [7:0] addr);
    int idx;
    idx = -1;
    if (addr >= ADDR_EP_BASE && addr[1:0] == 2'b00)
    begin
      idx = int'((addr - ADDR_EP_BASE) >> 2);
      if (idx >= NUM_EP)
      begin
        idx = -1;
      end
    end
    return idx;
  endfunction : ep_index

  // derived endpoint view for the packet engine
  function automatic ep_ctrl_t ep_decode(input logic [7:0] r);
    ep_ctrl_t c;
    c.rx_en = r[EP_RX_BIT];
    c.tx_en = r[EP_TX_BIT];
    c.setup_ok = !(r[EP_CONDIS_BIT] && r[EP_TX_BIT] && r[EP_RX_BIT]);
    c.handshake_en = r[EP_HSHK_BIT];
    c.stalled = r[EP_STALL_BIT];
    return c;
  endfunction : ep_decode

  // next-state logic: register writes, reads, events
  always_comb
  begin
    int idx;
    logic [IRQ_WIDTH-1:0] ev;
    idx = ep_index(i_req.addr);
    ev = '0;
    next_st = st;
    next_st.rdata = BUS_ZERO;
    // any stall event raises the stall interrupt event
    for (int e = 0; e < NUM_EP; e++)
    begin
      if (i_stall_event[e])
      begin
        ev[IRQ_STALL_BIT] = 1'b1;
      end
    end
    if (i_sleep_entry && st.config1[CFG_ASUSP_BIT])
    begin
      ev[IRQ_SUSPEND_BIT] = 1'b1;
    end
    if (i_req.wr)
    begin
      // only the low byte is stored
      unique case (i_req.addr)
        ADDR_BDT_PAGE1: next_st.page1 = i_req.wdata[7:0] & PAGE1_WMASK;
        ADDR_BDT_PAGE2: next_st.page2 = i_req.wdata[7:0];
        ADDR_BDT_PAGE3: next_st.page3 = i_req.wdata[7:0];
        ADDR_CONFIG1: next_st.config1 = i_req.wdata[7:0] & CFG_WMASK;
        // write one to clear
        ADDR_IRQ_STATUS: next_st.irq_status = st.irq_status & ~i_req.wdata[IRQ_WIDTH-1:0];
        ADDR_IRQ_MASK: next_st.irq_mask = i_req.wdata[IRQ_WIDTH-1:0];
        default:
        begin
          if (idx == 0)
          begin
            next_st.ep[0] = i_req.wdata[7:0] & EP0_WMASK;
          end
          else if (idx > 0)
          begin
            next_st.ep[idx] = i_req.wdata[7:0] & EPN_WMASK;
          end
        end
      endcase
    end
    // stall set wins over a same-cycle write
    for (int e = 0; e < NUM_EP; e++)
    begin
      if (i_stall_event[e])
      begin
        next_st.ep[e][EP_STALL_BIT] = 1'b1;
      end
    end
    // set wins over a same-cycle clear
    next_st.irq_status = next_st.irq_status | ev;
    if (i_req.rd)
    begin
      unique case (i_req.addr)
        ADDR_BDT_PAGE1: next_st.rdata = {24'h000000, st.page1};
        ADDR_BDT_PAGE2: next_st.rdata = {24'h000000, st.page2};
        ADDR_BDT_PAGE3: next_st.rdata = {24'h000000, st.page3};
        ADDR_CONFIG1: next_st.rdata = {24'h000000, st.config1};
        ADDR_IRQ_STATUS: next_st.rdata = {{(32-IRQ_WIDTH){1'b0}}, st.irq_status};
        ADDR_IRQ_MASK: next_st.rdata = {{(32-IRQ_WIDTH){1'b0}}, st.irq_mask};
        // live input levels for software
        ADDR_HW_EVENT: next_st.rdata = {30'h0, i_sleep_entry, i_idle_mode};
        default:
        begin
          // unmapped addresses read zero
          if (idx >= 0)
          begin
            next_st.rdata = {24'h000000, st.ep[idx]};
          end
        end
      endcase
    end
    next_st.bdt_base = {next_st.page3, next_st.page2, next_st.page1[7:1], 9'h000};
    next_st.eye = next_st.config1[CFG_EYE_BIT];
    next_st.mon = next_st.config1[CFG_MON_BIT];
    next_st.halted = next_st.config1[CFG_IDLE_BIT] && i_idle_mode;
    // auto suspend request, held while sleep entry lasts
    // otherwise suspend is left to power control software
    next_st.asusp = next_st.config1[CFG_ASUSP_BIT] && i_sleep_entry;
    next_st.low_speed_direct = next_st.ep[0][EP_LOW_SPEED_DIRECT_BIT];
    next_st.retry_en = !next_st.ep[0][EP_RETRY_BIT];
    for (int e = 0; e < NUM_EP; e++)
    begin
      next_st.ep_ctrl[e] = ep_decode(next_st.ep[e]);
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      st <= '0;
      st.page1 <= REG_RESET;
      st.ep_ctrl <= '{default: '{setup_ok: 1'b1, default: 1'b0}};
      st.retry_en <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign o_rdata = st.rdata;
  assign o_bdt_base = st.bdt_base;
  assign o_eye_pattern_test_en = st.eye;
  assign o_drive_monitor_en = st.mon;
  assign o_module_halted = st.halted;
  assign o_auto_suspend_req = st.asusp;
  assign o_low_speed_direct = st.low_speed_direct;
  assign o_nak_retry_en = st.retry_en;
  assign o_ep_ctrl = st.ep_ctrl;
  assign o_irq = st.irq;
endmodule : usb_endpoint_config_regs

// file: test/usb_peer_model.sv
// Purpose: far-side usb peer that stalls endpoint zero
// Assumes: one clock, command held one cycle
// Notes: stall arrives as a one-cycle pulse
`timescale 1ns/1ps
module usb_peer_model (
  input wire logic i_clk,
  input wire logic i_stall_cmd,
  output logic [15:0] o_stall_event
);
  always_ff @(posedge i_clk)
  begin
    o_stall_event <= {15'h0000, i_stall_cmd};
  end
endmodule : usb_peer_model

// file: test/usb_cfg_asserts.sv
// Purpose: port checks for the config registers
// Assumes: sync active-low reset
// Notes: ep0 stands for all endpoints
`timescale 1ns/1ps
module usb_cfg_asserts
  import usb_cfg_pkg::*;
#(
  parameter int NUM_EP = 16
)(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire usb_cfg_pkg::reg_req_t i_req,
  input wire logic [NUM_EP-1:0] i_stall_event,
  input wire logic i_idle_mode,
  input wire logic i_sleep_entry,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_bdt_base,
  input wire logic o_eye_pattern_test_en,
  input wire logic o_module_halted,
  input wire logic o_auto_suspend_req,
  input wire usb_cfg_pkg::ep_ctrl_t [NUM_EP-1:0] o_ep_ctrl
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // write to the config word
  sequence s_cfg_wr;
    i_req.wr && i_req.addr == ADDR_CONFIG1;
  endsequence
  a_base_align: assert property (o_bdt_base[8:0] == 9'h000)
    else $error("base not aligned");
  a_eye_write: assert property (s_cfg_wr |=> o_eye_pattern_test_en == $past(i_req.wdata[7]))
    else $error("eye bit not taken");
  a_rdata_quiet: assert property (!i_req.rd |=> o_rdata == BUS_ZERO)
    else $error("read data without read");
  a_rdata_high: assert property (o_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_halt_idle: assert property (!i_idle_mode |=> !o_module_halted)
    else $error("halted outside idle");
  a_susp_sleep: assert property (!i_sleep_entry |=> !o_auto_suspend_req)
    else $error("suspend without sleep");
  a_setup_gate: assert property (!(o_ep_ctrl[0].tx_en && o_ep_ctrl[0].rx_en) |-> o_ep_ctrl[0].setup_ok)
    else $error("setup refused on one-way endpoint");
  a_stall_set: assert property (i_stall_event[0] |=> o_ep_ctrl[0].stalled)
    else $error("stall not recorded");
endmodule : usb_cfg_asserts
bind usb_endpoint_config_regs usb_cfg_asserts #(.NUM_EP(NUM_EP)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_req(i_req), .i_stall_event(i_stall_event), .i_idle_mode(i_idle_mode), .i_sleep_entry(i_sleep_entry),
  .o_rdata(o_rdata), .o_bdt_base(o_bdt_base), .o_eye_pattern_test_en(o_eye_pattern_test_en),
  .o_module_halted(o_module_halted), .o_auto_suspend_req(o_auto_suspend_req), .o_ep_ctrl(o_ep_ctrl));

// file: test/usb_endpoint_config_regs_tb.sv
// Purpose: self-checking bench for the config registers
// Assumes: read data in the cycle after the strobe
// Notes: rows cover the page, config and endpoint 0 and 15 registers and one unmapped address, then hand tests
`timescale 1ns/1ps
module usb_endpoint_config_regs_tb;
  import usb_cfg_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  reg_req_t req = '0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic stall_cmd = 1'b0;
  logic [15:0] stall;
  logic [31:0] rdata, base;
  logic eye, mon, halt, asusp, lsd, retry, irq;
  ep_ctrl_t [15:0] ep;
  int mismatches = 0;
  int n_compared = 0;
  // write all ones, expect only implemented bits back
  row_t rows [7] = '{'{ADDR_BDT_PAGE1, 32'hffffffff, 32'h000000fe}, '{ADDR_BDT_PAGE2, 32'hffffffff, 32'h000000ff},
    '{ADDR_BDT_PAGE3, 32'hffffffff, 32'h000000ff}, '{ADDR_CONFIG1, 32'hffffffff, 32'h000000d1},
    '{ADDR_EP_BASE, 32'hffffffff, 32'h000000df}, '{8'h7c, 32'hffffffff, 32'h0000001f}, '{8'h3c, 32'hffffffff, 32'h0}};
  usb_endpoint_config_regs uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .i_stall_event(stall),
    .i_idle_mode(idle), .i_sleep_entry(sleep), .o_rdata(rdata), .o_bdt_base(base), .o_eye_pattern_test_en(eye),
    .o_drive_monitor_en(mon), .o_module_halted(halt), .o_auto_suspend_req(asusp), .o_low_speed_direct(lsd),
    .o_nak_retry_en(retry), .o_ep_ctrl(ep), .o_irq(irq));
  usb_peer_model peer (.i_clk(i_clk), .i_stall_cmd(stall_cmd), .o_stall_event(stall));
  initial forever #50 i_clk = ~i_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge i_clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge i_clk);
    req.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rdchk
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdchk(ADDR_CONFIG1, BUS_ZERO);
    chk("retry", 32'h1, {31'h0, retry});
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk("base", 32'hfffffe00, base);
    chk("flags", 32'h1c, {27'h0, eye, mon, lsd, retry, ep[0].setup_ok});
    $display("register rows done");
    wr(ADDR_EP_BASE, 32'h14);
    chk("ep0", 32'h6, {28'h0, ep[0].rx_en, ep[0].tx_en, ep[0].setup_ok, ep[0].handshake_en});
    @(posedge i_clk);
    idle <= 1'b1;
    sleep <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk("halt", 32'h3, {30'h0, halt, asusp});
    @(posedge i_clk);
    idle <= 1'b0;
    sleep <= 1'b0;
    wr(ADDR_IRQ_MASK, 32'h0);
    @(posedge i_clk);
    stall_cmd <= 1'b1;
    @(posedge i_clk);
    stall_cmd <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 chk("stall", 32'h2, {30'h0, ep[0].stalled, irq});
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge i_clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge i_clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    // auto suspend off: sleep must not raise the request, software suspends
    wr(ADDR_CONFIG1, 32'h0);
    sleep <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk("asusp", 32'h0, {31'h0, asusp});
    sleep <= 1'b0;
    $display("event tests done");
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdchk(ADDR_BDT_PAGE3, BUS_ZERO);
    chk("base", BUS_ZERO, base);
    $display("reset test done");
    give_verdict();
  end
  initial
  begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule : usb_endpoint_config_regs_tb
